/* File: core/loop_detector_scan_output.sv */
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "loop_detector_map.svh"

module loop_detector_scan_output
    import loop_detector_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int CW       = 20,
    parameter int SLOT_CYC = `LD_CLK_HZ / (`LD_SCAN_HZ * CHANNELS),
    parameter int MS_CYC   = `LD_CLK_HZ / `LD_MS_PER_S,
    parameter int HOLD_MS  = `LD_HOLD_MIN * `LD_MS_PER_MIN
)(
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [7:0]            awaddr,
    input  wire logic [2:0]            awprot,
    // AXI4-Lite write data
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    // AXI4-Lite write response
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // AXI4-Lite read address
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [7:0]            araddr,
    input  wire logic [2:0]            arprot,
    // AXI4-Lite read data
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    // Loop front end
    input  wire logic                  osc_in,
    output logic [CHANNELS-1:0]        osc_en,
    output logic                       freq_raise,
    output logic                       freq_lower,
    // Front panel
    input  wire logic                  reset_in,
    input  wire logic [4*CHANNELS-1:0] sel_in,
    output logic [CHANNELS-1:0]        lamp,
    // Isolated outputs
    output logic [CHANNELS-1:0]        det_out
);

    localparam int CIW = $clog2(CHANNELS);
    localparam int OW  = $clog2(((HOLD_MS > `LD_TUNEOUT_MS) ? HOLD_MS : `LD_TUNEOUT_MS) + 1);
    localparam int MW  = $clog2(MS_CYC);
    localparam int PW  = 8;
    localparam int XW  = CW + 20;

    localparam logic [OW-1:0] TUNEOUT = OW'(`LD_TUNEOUT_MS);
    localparam logic [OW-1:0] HOLD    = OW'(HOLD_MS);
    localparam logic [PW-1:0] PULSE   = PW'(`LD_PULSE_MS);

    function automatic logic [7:0] thr_units(input logic [2:0] s);
        case (s)
            3'h0:    thr_units = `LD_THR0;
            3'h1:    thr_units = `LD_THR1;
            3'h2:    thr_units = `LD_THR2;
            3'h3:    thr_units = `LD_THR3;
            3'h4:    thr_units = `LD_THR4;
            3'h5:    thr_units = `LD_THR5;
            3'h6:    thr_units = `LD_THR6;
            default: thr_units = `LD_THR7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic                  osc_s1;
    logic                  osc_s2;
    logic                  osc_s3;
    logic                  rst_s1;
    logic                  rst_s2;
    logic [4*CHANNELS-1:0] sel_s1;
    logic [4*CHANNELS-1:0] sel_s2;
    logic                  osc_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            sel_s1 <= '0;
            sel_s2 <= '0;
        end else begin
            osc_s1 <= osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            rst_s1 <= reset_in;
            rst_s2 <= rst_s1;
            sel_s1 <= sel_in;
            sel_s2 <= sel_s1;
        end
    end

    assign osc_edge = osc_s2 & ~osc_s3;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic             aw_got;
    logic             w_got;
    logic [7:0]       wa_reg;
    logic [31:0]      wd_reg;
    logic [3:0]       ws_reg;
    logic             do_wr;
    logic             ctrl_wr;
    logic             soft_rst_reg;
    logic [1:0]       msel_reg;
    logic [31:0]      rd_word;
    logic             rd_err;
    logic [CHANNELS-1:0] tuned_v;
    logic [CW-1:0]    ref_w [CHANNELS];
    logic [CW-1:0]    cnt_w [CHANNELS];
    logic [CIW-1:0]   msel_idx;

    assign do_wr    = aw_got & w_got & ~bvalid;
    assign ctrl_wr  = do_wr && wa_reg == `LD_REG_CTRL && ws_reg[0];
    assign msel_idx = msel_reg[CIW-1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            aw_got  <= 1'b0;
            wa_reg  <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            wa_reg  <= awaddr;
        end else if (do_wr) begin
            aw_got  <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            w_got  <= 1'b0;
            wd_reg <= '0;
            ws_reg <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_got  <= 1'b1;
            wd_reg <= wdata;
            ws_reg <= wstrb;
        end else if (do_wr) begin
            w_got  <= 1'b0;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `LD_RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (wa_reg > `LD_REG_REF || wa_reg[1:0] != 2'h0) ? `LD_RESP_SLVERR : `LD_RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control register; the reset bit is a one-cycle strobe, never stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_raise   <= 1'b0;
            freq_lower   <= 1'b0;
            msel_reg     <= '0;
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= ctrl_wr & wd_reg[`LD_CTRL_RST_BIT];
            if (ctrl_wr) begin
                freq_raise <= wd_reg[`LD_CTRL_RAISE_BIT];
                freq_lower <= wd_reg[`LD_CTRL_LOWER_BIT] & ~wd_reg[`LD_CTRL_RAISE_BIT];
                msel_reg   <= wd_reg[`LD_CTRL_SEL_LSB +: 2];
            end
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        case (araddr)
            `LD_REG_CTRL: begin
                rd_word[`LD_CTRL_RAISE_BIT]     = freq_raise;
                rd_word[`LD_CTRL_LOWER_BIT]     = freq_lower;
                rd_word[`LD_CTRL_SEL_LSB +: 2]  = msel_reg;
            end
            `LD_REG_STATUS: begin
                rd_word[CHANNELS-1:0]                     = det_out;
                rd_word[`LD_STAT_TUNED_LSB +: CHANNELS]   = tuned_v;
            end
            `LD_REG_SWITCH: rd_word[4*CHANNELS-1:0] = sel_s2;
            `LD_REG_COUNT:  rd_word[CW-1:0]         = cnt_w[msel_idx];
            `LD_REG_REF:    rd_word[CW-1:0]         = ref_w[msel_idx];
            default:        rd_err                  = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `LD_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_err ? `LD_RESP_SLVERR : `LD_RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan, millisecond tick and channel clear

    logic           meas_done;
    logic [CIW-1:0] meas_ch;
    logic [CW-1:0]  meas_cnt;
    logic [MW-1:0]  ms_cnt;
    logic           ms_tick;
    logic           chan_clr;

    // Power-up runs through aresetn, so recovery needs no operator
    assign chan_clr = ~aresetn | rst_s2 | soft_rst_reg;

    loop_scan_meas #(
        .CHANNELS (CHANNELS),
        .CW       (CW),
        .SLOT_CYC (SLOT_CYC),
        .CIW      (CIW)
    ) u_scan (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .osc_edge (osc_edge),
        .osc_en   (osc_en),
        .done     (meas_done),
        .done_ch  (meas_ch),
        .done_cnt (meas_cnt)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt  <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == MW'(MS_CYC - 1));
            ms_cnt  <= (ms_cnt == MW'(MS_CYC - 1)) ? '0 : ms_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel tracking and output

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        logic [3:0]    pos;
        mode_e         md;
        logic          upd;
        logic          gt;
        logic [XW-1:0] lhs;
        logic [XW-1:0] rhs;
        logic          hit_on;
        logic          hit_keep;
        logic          tune_out;
        logic [CW-1:0] ref_reg;
        logic [CW-1:0] last_reg;
        logic          tuned_reg;
        logic          det_reg;
        logic [OW-1:0] occ_reg;
        logic [PW-1:0] pul_reg;
        logic          out_reg;
        logic          lamp_reg;
        logic          out_next;

        assign pos = sel_s2[4*g +: 4];
        always_comb begin
            if (pos == `LD_SEL_OFF)
                md = MODE_OFF;
            else if (pos[`LD_SEL_PRES_BIT])
                md = MODE_PRES;
            else
                md = MODE_PULSE;
        end

        assign upd = meas_done && meas_ch == CIW'(g);
        assign gt  = meas_cnt > ref_reg;
        assign lhs = XW'(meas_cnt - ref_reg) * XW'(`LD_THR_DEN);
        assign rhs = XW'(ref_reg) * XW'(thr_units(pos[2:0]));
        // Release at half the threshold so noise cannot split one vehicle
        assign hit_on   = gt && lhs > rhs;
        assign hit_keep = gt && (lhs << 1) > rhs;
        assign tune_out = det_reg && ((md == MODE_PULSE && occ_reg >= TUNEOUT)
                          || occ_reg >= HOLD);

        // No fault state: a shorted loop is measured and tracked like any other
        always_ff @(posedge aclk) begin
            if (chan_clr) begin
                ref_reg   <= '0;
                last_reg  <= '0;
                tuned_reg <= 1'b0;
                det_reg   <= 1'b0;
            end else if (upd) begin
                last_reg <= meas_cnt;
                if (!tuned_reg) begin
                    ref_reg   <= meas_cnt;
                    tuned_reg <= 1'b1;
                end else if (tune_out) begin
                    ref_reg <= meas_cnt;
                    det_reg <= 1'b0;
                end else if (det_reg ? hit_keep : hit_on) begin
                    det_reg <= 1'b1;
                end else begin
                    det_reg <= 1'b0;
                    if (gt)
                        ref_reg <= ref_reg + 1'b1;
                    else if (meas_cnt < ref_reg)
                        ref_reg <= ref_reg - 1'b1;
                end
            end
        end

        always_ff @(posedge aclk) begin
            if (chan_clr || !det_reg)
                occ_reg <= '0;
            else if (ms_tick && occ_reg != '1)
                occ_reg <= occ_reg + 1'b1;
        end

        always_ff @(posedge aclk) begin
            if (chan_clr)
                pul_reg <= '0;
            else if (upd && tuned_reg && !det_reg && hit_on && md == MODE_PULSE)
                pul_reg <= PULSE;
            else if (ms_tick && pul_reg != '0)
                pul_reg <= pul_reg - 1'b1;
        end

        always_comb begin
            unique case (md)
                MODE_OFF:   out_next = 1'b0;
                MODE_PULSE: out_next = pul_reg != '0;
                MODE_PRES:  out_next = det_reg;
            endcase
        end

        always_ff @(posedge aclk) begin
            if (chan_clr) begin
                out_reg  <= 1'b0;
                lamp_reg <= 1'b0;
            end else begin
                out_reg  <= out_next;
                lamp_reg <= out_next;
            end
        end

        assign det_out[g] = out_reg;
        assign lamp[g]    = lamp_reg;
        assign tuned_v[g] = tuned_reg;
        assign ref_w[g]   = ref_reg;
        assign cnt_w[g]   = last_reg;
    end

endmodule // loop_detector_scan_output

/* File: core/loop_detector_map.svh */
`ifndef LOOP_DETECTOR_MAP_SVH
`define LOOP_DETECTOR_MAP_SVH

// Timebase and timing figures
`define LD_CLK_HZ         100000000
`define LD_SCAN_HZ        148
`define LD_MS_PER_S       1000
`define LD_PULSE_MS       225
`define LD_TUNEOUT_MS     2000
`define LD_HOLD_MIN       30
`define LD_MS_PER_MIN     60000

// Sensitivity steps in units of 1/THR_DEN (0.0025 % each)
`define LD_THR_DEN        40000
`define LD_THR0           8'h01
`define LD_THR1           8'h02
`define LD_THR2           8'h04
`define LD_THR3           8'h08
`define LD_THR4           8'h10
`define LD_THR5           8'h21
`define LD_THR6           8'h42
`define LD_THR7           8'h84

// Register byte offsets
`define LD_REG_CTRL       8'h00
`define LD_REG_STATUS     8'h04
`define LD_REG_SWITCH     8'h08
`define LD_REG_COUNT      8'h0C
`define LD_REG_REF        8'h10

// Field positions and values
`define LD_CTRL_RST_BIT   0
`define LD_CTRL_RAISE_BIT 1
`define LD_CTRL_LOWER_BIT 2
`define LD_CTRL_SEL_LSB   4
`define LD_STAT_TUNED_LSB 8
`define LD_SEL_OFF        4'h0
`define LD_SEL_PRES_BIT   3
`define LD_RESP_OKAY      2'h0
`define LD_RESP_SLVERR    2'h2

`endif

/* File: core/loop_detector_pkg.sv */
package loop_detector_pkg;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_PULSE,
        MODE_PRES
    } mode_e;

endpackage

/* File: core/loop_scan_meas.sv */
`timescale 1ns/10ps

// Round-robin scan: one oscillator at a time, edges counted per slot
module loop_scan_meas #(
    parameter int CHANNELS = 4,
    parameter int CW       = 20,
    parameter int SLOT_CYC = 168918,
    parameter int CIW      = 2
)(
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Synchronised oscillator edge
    input  wire logic                osc_edge,
    // Scan outputs
    output logic [CHANNELS-1:0]      osc_en,
    output logic                     done,
    output logic [CIW-1:0]           done_ch,
    output logic [CW-1:0]            done_cnt
);

    localparam int SW = $clog2(SLOT_CYC + 1);
    localparam logic [SW-1:0] LAST = SW'(SLOT_CYC - 1);

    logic [SW-1:0]  slot_reg;
    logic [CIW-1:0] ch_reg;
    logic [CW-1:0]  cnt_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_reg <= '0;
            ch_reg   <= '0;
        end else if (slot_reg == LAST) begin
            slot_reg <= '0;
            ch_reg   <= (ch_reg == CIW'(CHANNELS - 1)) ? '0 : ch_reg + 1'b1;
        end else begin
            slot_reg <= slot_reg + 1'b1;
        end
    end

    // Registered enable is dead for slot counts 0 and 1, at the start of each slot, so two oscillators never overlap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_en <= '0;
        end else if (slot_reg != '0 && slot_reg != LAST) begin
            osc_en <= CHANNELS'(1) << ch_reg;
        end else begin
            osc_en <= '0;
        end
    end

    // Saturating count keeps very low inductances (high frequency) usable
    always_ff @(posedge aclk) begin
        if (!aresetn || slot_reg == '0) begin
            cnt_reg <= '0;
        end else if (osc_edge && osc_en != '0 && cnt_reg != '1) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done     <= 1'b0;
            done_ch  <= '0;
            done_cnt <= '0;
        end else begin
            done <= (slot_reg == LAST);
            if (slot_reg == LAST) begin
                done_ch  <= ch_reg;
                done_cnt <= cnt_reg;
            end
        end
    end

endmodule // loop_scan_meas

/* File: bench/loop_detector_props.sv */
`timescale 1ns/10ps
`include "loop_detector_map.svh"

module loop_detector_props #(
    parameter int CHANNELS = 4,
    parameter int SLOT_CYC = 40
)(
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Read channels
    input wire logic                  arvalid,
    input wire logic                  arready,
    input wire logic [7:0]            araddr,
    input wire logic                  rvalid,
    input wire logic [31:0]           rdata,
    input wire logic [1:0]            rresp,
    // Front end and panel
    input wire logic [CHANNELS-1:0]   osc_en,
    input wire logic                  freq_raise,
    input wire logic                  freq_lower,
    input wire logic                  reset_in,
    input wire logic [4*CHANNELS-1:0] sel_in,
    input wire logic [CHANNELS-1:0]   lamp,
    input wire logic [CHANNELS-1:0]   det_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    localparam int SWEEP = CHANNELS * SLOT_CYC;
    int gap_cnt;
    int off_cnt;
    int rst_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Run lengths; a stalled scan or a slow clear shows up as a large count
    always_ff @(posedge aclk) begin
        gap_cnt <= (!aresetn || osc_en[0]) ? 0 : gap_cnt + 1;
        off_cnt <= (!aresetn || sel_in[7:4] != `LD_SEL_OFF) ? 0 : off_cnt + 1;
        rst_cnt <= (!aresetn || !reset_in) ? 0 : rst_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_osc_one_hot: assert property ($onehot0(osc_en))
        else $error("two oscillators enabled");
    a_scan_gap: assert property (gap_cnt <= SWEEP)
        else $error("channel 0 not visited within one sweep");
    a_scan_next: assert property ($fell(osc_en[0]) |-> ##[1:3] osc_en[1])
        else $error("channel 1 does not follow channel 0");
    a_lamp_equal: assert property (lamp == det_out)
        else $error("lamp differs from output");
    a_off_quiet: assert property (off_cnt > SWEEP + 8 |-> !det_out[1] && !lamp[1])
        else $error("output active on an off channel");
    a_reset_clear: assert property (rst_cnt > 4 |-> det_out == '0)
        else $error("detection survives panel reset");
    a_freq_excl: assert property (!(freq_raise && freq_lower))
        else $error("raise and lower both active");
    a_read_slverr: assert property (arvalid && arready && araddr > `LD_REG_REF
        |=> rvalid && rresp == `LD_RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_status_read: assert property (arvalid && arready && araddr == `LD_REG_STATUS
        |=> rvalid && rresp == `LD_RESP_OKAY && rdata[CHANNELS-1:0] == $past(det_out))
        else $error("status read wrong");

    c_detect: cover property ($rose(det_out[0]));
    c_pulse_end: cover property ($fell(det_out[0]) && !sel_in[`LD_SEL_PRES_BIT]);
    c_refused: cover property (rvalid && rresp == `LD_RESP_SLVERR);
endmodule // loop_detector_props

bind loop_detector_scan_output loop_detector_props #(.CHANNELS(CHANNELS), .SLOT_CYC(SLOT_CYC)) props_u (
    .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .osc_en(osc_en), .freq_raise(freq_raise),
    .freq_lower(freq_lower), .reset_in(reset_in), .sel_in(sel_in), .lamp(lamp), .det_out(det_out));

/* File: bench/loop_front_model.sv */
`timescale 1ns/10ps

// Shared loop oscillator: three times faster while a vehicle sits on the enabled loop
module loop_front_model #(
    parameter int CHANNELS = 4
)(
    input  wire logic                aclk,
    input  wire logic [CHANNELS-1:0] osc_en,
    input  wire logic [CHANNELS-1:0] veh,
    output logic                     osc_in
);
    int half;
    int phase = 0;

    initial osc_in = 1'b0;

    always @(posedge aclk) begin
        half = ((osc_en & veh) != '0) ? 1 : 3;
        // Oscillator stands still between slots, so gap edges cannot be miscounted
        if (osc_en == '0) begin
            osc_in <= 1'b0;
            phase  <= 0;
        end else if (phase >= half - 1) begin
            osc_in <= ~osc_in;
            phase  <= 0;
        end else begin
            phase <= phase + 1;
        end
    end
endmodule // loop_front_model

/* File: bench/tb_loop_detector_scan_output.sv */
`timescale 1ns/10ps
`include "loop_detector_map.svh"

module tb_loop_detector_scan_output;
    localparam int SWEEP   = 160;
    localparam int PULSE_C = 2250;
    localparam int HOLD_C  = 21000;

    logic        aclk;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        reset_in = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [3:0]  wstrb = 4'hf;
    logic [2:0]  prot = 3'h0;
    logic [31:0] wdata = 32'h0000_0000, rd, rdata;
    logic [15:0] sel_in = 16'h8888;
    logic [3:0]  veh = 4'h0, osc_en, lamp, det_out;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, osc_in, freq_raise, freq_lower;
    logic [31:0] ctrl_v [3] = '{32'h0000_0002, 32'h0000_0006, 32'h0000_0004};
    logic [1:0]  ctrl_x [3] = '{2'h2, 2'h2, 2'h1};
    int          seed = 32'h5a49;
    int          err_total = 0, samples_checked = 0, ch, w;

    loop_detector_scan_output #(.CHANNELS(4), .SLOT_CYC(40), .MS_CYC(10), .HOLD_MS(2100)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(prot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .osc_in(osc_in), .osc_en(osc_en), .freq_raise(freq_raise),
        .freq_lower(freq_lower), .reset_in(reset_in), .sel_in(sel_in), .lamp(lamp), .det_out(det_out));

    loop_front_model #(.CHANNELS(4)) front_u (.aclk(aclk), .osc_en(osc_en), .veh(veh), .osc_in(osc_in));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr  <= a;
        prot    <= 3'($random(seed));
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        prot    <= 3'($random(seed));
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Waits for channel 0 to assert, then returns how long it stayed high
    task automatic pulse_len(output int len);
        int n = 0;
        len = 0;
        while (det_out[0] !== 1'b1 && n < 4 * SWEEP) begin
            @(posedge aclk);
            n++;
        end
        while (det_out[0] === 1'b1 && len < 3 * PULSE_C) begin
            @(posedge aclk);
            len++;
        end
    endtask

    // Pulse length in clocks may stray by up to two millisecond ticks
    function automatic logic near(input int v, input int e);
        return v >= e - 20 && v <= e + 20;
    endfunction

    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(100000);
        err_total++;
        print_verdict;
    end

    initial begin
        wait_cyc(20);
        aresetn <= 1'b1;
        axi_read(`LD_REG_STATUS, rd, rs);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            axi_write(`LD_REG_CTRL, ctrl_v[i], rs);
            chk({freq_raise, freq_lower}, ctrl_x[i]);
        end
        axi_write(8'h14, 32'h0000_0002, rs);
        chk({rs, freq_raise}, {`LD_RESP_SLVERR, 1'b0});
        axi_read(8'h13, rd, rs);
        chk(rs, `LD_RESP_SLVERR);
        wstrb <= 4'he;
        axi_write(`LD_REG_CTRL, 32'h0000_0002, rs);
        chk({rs, freq_raise}, {`LD_RESP_OKAY, 1'b0});
        wstrb <= 4'hf;
        axi_write(`LD_REG_CTRL, 32'h0000_0000, rs);
        for (int i = 0; i < 4; i++) sel_in[4*i +: 4] <= {1'b1, 3'($random(seed))};
        wait_cyc(4 * SWEEP);
        axi_read(`LD_REG_SWITCH, rd, rs);
        chk(rd[15:0], sel_in);
        axi_read(`LD_REG_STATUS, rd, rs);
        chk(rd, 32'h0000_0f00);
        repeat (6) begin
            ch = $random(seed) & 3;
            veh[ch] <= 1'b1;
            wait_cyc(2 * SWEEP);
            repeat (SWEEP) begin
                @(posedge aclk);
                chk(det_out, 32'h1 << ch);
            end
            chk(lamp, 32'h1 << ch);
            veh[ch] <= 1'b0;
            wait_cyc(3 * SWEEP);
            chk(det_out, 32'h0);
        end
        // Off channel with a vehicle, then panel reset with all loops occupied
        sel_in[7:4] <= `LD_SEL_OFF;
        veh[1] <= 1'b1;
        wait_cyc(3 * SWEEP);
        chk({lamp[1], det_out[1]}, 2'b00);
        sel_in[7:4] <= 4'h8;
        veh <= 4'hf;
        wait_cyc(3 * SWEEP);
        chk(det_out, 4'hf);
        reset_in <= 1'b1;
        wait_cyc(SWEEP);
        chk(det_out, 4'h0);
        reset_in <= 1'b0;
        wait_cyc(3 * SWEEP);
        chk(det_out, 4'h0);
        veh <= 4'h0;
        wait_cyc(SWEEP);
        axi_write(`LD_REG_CTRL, 32'h0000_0001, rs);
        wait_cyc(3 * SWEEP);
        // Long stay in presence mode is held, then absorbed
        veh[2] <= 1'b1;
        wait_cyc(HOLD_C - 20);
        chk(det_out[2], 1'b1);
        wait_cyc(420);
        chk(det_out[2], 1'b0);
        veh[2] <= 1'b0;
        sel_in[3:0] <= 4'(1 + (($random(seed) & 255) % 7));
        wait_cyc(3 * SWEEP);
        veh[0] <= 1'b1;
        pulse_len(w);
        chk(near(w, PULSE_C), 1'b1);
        axi_read(`LD_REG_REF, rd, rs);
        chk(rd < 12, 1'b1);
        wait_cyc(20000);
        axi_read(`LD_REG_REF, rd, rs);
        chk(rd > 15, 1'b1);
        veh[0] <= 1'b0;
        wait_cyc(20 * SWEEP);
        veh[0] <= 1'b1;
        pulse_len(w);
        chk(w > 0, 1'b1);
        print_verdict;
    end
endmodule // tb_loop_detector_scan_output
